// >>> hw/periph_map_consts.vh
/*
 holds address windows, identifier numbers and reset values for the
 peripheral identifier map. assumes nothing; definitions only.
*/
`ifndef PERIPH_MAP_CONSTS_VH
`define PERIPH_MAP_CONSTS_VH

// address windows
`define SYS_WIN_LO      32'hffffe800
`define SYS_WIN_HI      32'hffffffff
`define USR_WIN_LO      32'hfffa0000
`define USR_WIN_HI      32'hfffcffff
`define USR_SLOT_SHIFT  14
`define USR_SLOT_COUNT  12

// identifiers
`define ID_FAST         0
`define ID_SYSTEM       1
`define ID_FIRST_LOW    2
`define ID_LAST_LOW     14
`define ID_FIRST_HIGH   17
`define ID_USB_HOST     20
`define ID_LAST_HIGH    28
`define ID_EXT0         29
`define ID_EXT1         30
`define ID_EXT2         31

// identifiers with no clock gate: 0, 1, 20, 29, 30, 31
`define NO_CLOCK_MASK   32'he0100003
// clocks of the system group never stop
`define SYS_CLK_ON      7'h7f
`define BACKUP_RESET    32'h00000000
`define BACKUP_COUNT    4

`endif

// >>> hw/periph_id_map.v
/*
 holds the peripheral identifier map: interrupt vector, clock gates,
 address window decode and backup registers. assumes all inputs share
 core_clk_i except the fast interrupt pin and the three external
 interrupt pins, which are synchronised here.
*/
`timescale 1ns/1ps
`include "periph_map_consts.vh"

module periph_id_map
#(
    parameter BACKUP_COUNT = `BACKUP_COUNT
)
(
    // clock and reset
    input  wire        core_clk_i,
    input  wire        rst_i,
    // interrupt sources
    input  wire        fast_interrupt_input_i,
    input  wire        external_irq_line_0_i,
    input  wire        external_irq_line_1_i,
    input  wire        external_irq_line_2_i,
    input  wire [6:0]  sys_irq_i,
    input  wire [12:0] low_irq_i,
    input  wire [11:0] high_irq_i,
    // interrupt controller side
    output reg  [31:0] vectored_irq_controller_o,
    output reg         system_group_interrupt_o,
    // clock manager side
    input  wire        clk_enable_wr_i,
    input  wire        clk_disable_wr_i,
    input  wire [31:0] clk_wr_data_i,
    output reg  [31:0] power_clock_manager_o,
    output wire [6:0]  sys_clk_on_o,
    // address decode
    input  wire [31:0] addr_i,
    output reg         sys_sel_o,
    output reg         usr_sel_o,
    output reg  [3:0]  usr_slot_o,
    // backup registers
    input  wire        backup_wr_i,
    input  wire [1:0]  backup_idx_i,
    input  wire [31:0] backup_wr_data_i,
    output reg  [31:0] backup_rd_data_o
);

    reg [3:0]  ext_meta_reg;
    reg [3:0]  ext_sync_reg;
    reg [31:0] irq_next;
    reg [31:0] gate_next;
    reg [31:0] backup_reg [0:BACKUP_COUNT-1];
    wire [31:0] usr_off;
    integer i;

    function in_range;
        input [31:0] a;
        input [31:0] lo;
        input [31:0] hi;
        begin
            in_range = (a >= lo) && (a <= hi);
        end
    endfunction

    // strip ids that have no clock gate from a write mask
    function [31:0] allowed_gates;
        input [31:0] mask;
        begin
            allowed_gates = mask & ~`NO_CLOCK_MASK;
        end
    endfunction

    assign usr_off = addr_i - `USR_WIN_LO;
    assign sys_clk_on_o = `SYS_CLK_ON;

    // two-stage sync of external pins
    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ext_meta_reg <= 4'h0;
            ext_sync_reg <= 4'h0;
        end
        else
        begin
            ext_meta_reg <= {external_irq_line_2_i, external_irq_line_1_i,
                             external_irq_line_0_i, fast_interrupt_input_i};
            ext_sync_reg <= ext_meta_reg;
        end
    end

    // assemble request vector
    always @*
    begin
        irq_next = 32'h00000000;
        irq_next[`ID_FAST] = ext_sync_reg[0];
        irq_next[`ID_SYSTEM] = |sys_irq_i;
        irq_next[`ID_LAST_LOW:`ID_FIRST_LOW] = low_irq_i;
        irq_next[`ID_LAST_HIGH:`ID_FIRST_HIGH] = high_irq_i;
        irq_next[`ID_EXT2:`ID_EXT0] = ext_sync_reg[3:1];
    end

    // clock gate update, forbidden ids masked
    always @*
    begin
        gate_next = power_clock_manager_o;
        if (clk_enable_wr_i)
            gate_next = gate_next | allowed_gates(clk_wr_data_i);
        if (clk_disable_wr_i)
            gate_next = gate_next & ~allowed_gates(clk_wr_data_i);
    end

    // request vector and system line registers
    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            vectored_irq_controller_o <= 32'h00000000;
            system_group_interrupt_o  <= 1'b0;
        end
        else
        begin
            vectored_irq_controller_o <= irq_next;
            system_group_interrupt_o  <= irq_next[`ID_SYSTEM];
        end
    end

    // clock gate state register
    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            power_clock_manager_o <= 32'h00000000;
        end
        else
        begin
            power_clock_manager_o <= gate_next;
        end
    end

    // address window decode registers
    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sys_sel_o  <= 1'b0;
            usr_sel_o  <= 1'b0;
            usr_slot_o <= 4'h0;
        end
        else
        begin
            sys_sel_o <= in_range(addr_i, `SYS_WIN_LO, `SYS_WIN_HI);
            usr_sel_o <= in_range(addr_i, `USR_WIN_LO, `USR_WIN_HI);
            usr_slot_o <= usr_off[17:14];
        end
    end

    // backup read port
    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            backup_rd_data_o <= `BACKUP_RESET;
        end
        else
        begin
            backup_rd_data_o <= backup_reg[backup_idx_i];
        end
    end

    // backup registers, cleared by rst_i like every other register here
    always @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (i = 0; i < BACKUP_COUNT; i = i + 1)
                backup_reg[i] <= `BACKUP_RESET;
        end
        else if (backup_wr_i)
            backup_reg[backup_idx_i] <= backup_wr_data_i;
    end

endmodule

// >>> test/clk_mgr_model.sv
/* clock manager model: issues gate writes. assumes bench clock. */
`timescale 1ns/1ps
module clk_mgr_model(input wire core_clk_i,output reg en_o,dis_o,
    output reg [31:0] data_o);
    initial {en_o,dis_o,data_o}=0;
    task wr(input e,d,input [31:0] m);
        en_o<=e;
        dis_o<=d;
        data_o<=m;
        @(posedge core_clk_i);
        {en_o,dis_o}<=0;
        data_o<=~m;
    endtask
endmodule

// >>> test/periph_id_map_properties.sv
/* checker on the identifier map ports; bound below. */
`timescale 1ns/1ps
module periph_id_map_properties(input wire core_clk_i,rst_i,
    external_irq_line_0_i,system_group_interrupt_o,sys_sel_o,usr_sel_o,
    input wire [6:0] sys_irq_i,input wire [12:0] low_irq_i,input wire
    [31:0] vectored_irq_controller_o,power_clock_manager_o,addr_i);
    wire [31:0] v=vectored_irq_controller_o;
    wire [31:0] a=addr_i;
    wire g=system_group_interrupt_o;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    sequence ext_rise; $rose(external_irq_line_0_i); endsequence
    sys_or_a: assert property(g==|$past(sys_irq_i)) else $error("or");
    vec_sys_a: assert property(v[1]==g) else $error("id1");
    low_map_a: assert property(v[14:2]==$past(low_irq_i)) else $error("low");
    rsvd_zero_a: assert property(v[16:15]==0) else $error("rsvd");
    ext_lat_a: assert property(ext_rise|->##3 v[29]) else $error("ext");
    no_gate_a: assert property((power_clock_manager_o&32'he0100003)==0)
        else $error("gate");
    sys_win_a: assert property(sys_sel_o==($past(a)>=32'hffffe800))
        else $error("sys");
    usr_win_a: assert property(usr_sel_o==($past(a)>=32'hfffa0000&&
        $past(a)<=32'hfffcffff)) else $error("usr");
endmodule
bind periph_id_map periph_id_map_properties u_chk(.core_clk_i,.rst_i,
    .external_irq_line_0_i,.system_group_interrupt_o,.sys_sel_o,
    .usr_sel_o,.sys_irq_i,.low_irq_i,.vectored_irq_controller_o,
    .power_clock_manager_o,.addr_i);

// >>> test/test_periph_id_map.sv
/* bench for the identifier map; needs the clock manager model. */
`timescale 1ns/1ps
module test_periph_id_map;
logic c=0,r=1,f=0,bw=0;
logic [2:0] x=0;
logic [6:0] s=0;
logic [12:0] lo=0;
logic [11:0] hi=0;
logic [1:0] bi=0;
logic [31:0] a=0,bd=0;
wire ce,cd,g,ss,us;
wire [31:0] cv,v,pm,bq;
wire [6:0] so;
wire [3:0] sl;
int n_mismatch=0,n_tests=0;
initial forever #4 c=~c;
clk_mgr_model pmm(.core_clk_i(c),.en_o(ce),.dis_o(cd),.data_o(cv));
periph_id_map dut(.core_clk_i(c),.rst_i(r),.fast_interrupt_input_i(f),
 .external_irq_line_0_i(x[0]),.external_irq_line_1_i(x[1]),
 .external_irq_line_2_i(x[2]),.sys_irq_i(s),.low_irq_i(lo),
 .high_irq_i(hi),.vectored_irq_controller_o(v),
 .system_group_interrupt_o(g),.clk_enable_wr_i(ce),
 .clk_disable_wr_i(cd),.clk_wr_data_i(cv),.power_clock_manager_o(pm),
 .sys_clk_on_o(so),.addr_i(a),.sys_sel_o(ss),.usr_sel_o(us),
 .usr_slot_o(sl),.backup_wr_i(bw),.backup_idx_i(bi),
 .backup_wr_data_i(bd),.backup_rd_data_o(bq));
task chk(input string n,input [31:0] q,e);
 n_tests++;
 if(q!==e) begin n_mismatch++; $display("CHECK FAILED %s exp %h got %h",n,e,q); end
endtask
task stop_test;
 $display("tests %0d mismatches %0d",n_tests,n_mismatch);
 if(n_mismatch==0&&n_tests>0) $display("No errors found");
 else $display("Errors were found");
 $finish;
endtask
task t_sys;
 for(int i=0;i<7;i++) begin
  @(posedge c); s<=7'h1<<i;
  @(posedge c); #1 chk("sysirq",{g,v[1]},2'b11);
 end
 @(posedge c); s<=0;
 @(posedge c); #1 chk("sysirq",g,0);
 chk("sysclk",so,7'h7f);
endtask
task t_vec;
 @(posedge c); f<=1; x<=3'b101; lo<=13'h1555; hi<=12'haaa;
 repeat(3) @(posedge c); #1
 chk("vec",v,{3'b101,12'haaa,2'b00,13'h1555,2'b01});
endtask
task t_gate;
 @(posedge c); pmm.wr(1,0,32'hffffffff); #1
 chk("gate",pm,32'h1feffffc);
 @(posedge c); pmm.wr(0,1,32'h4); #1 chk("gate",pm,32'h1feffff8);
 @(posedge c); pmm.wr(1,1,32'h20000008); #1 chk("gate",pm,32'h1feffff0);
endtask
task t_addr;
 logic [31:0] t[6]='{32'hffffe7ff,32'hffffe800,32'hffffffff,
  32'hfff9ffff,32'hfffa0000,32'hfffcffff};
 logic [5:0] e[6]='{6'h0,6'h20,6'h20,6'h0,6'h10,6'h1b};
 for(int i=0;i<6;i++) begin
  @(posedge c); a<=t[i];
  @(posedge c); #1 chk("addr",{ss,us,us?sl:4'h0},e[i]);
 end
endtask
task t_bak;
 for(int i=0;i<4;i++) begin
  @(posedge c); bw<=1; bi<=i[1:0]; bd<=32'h11111111*(i+1);
 end
 @(posedge c); bw<=0;
 for(int i=0;i<4;i++) begin
  @(posedge c); bi<=i[1:0];
  @(posedge c); #1 chk("backup",bq,32'h11111111*(i+1));
 end
endtask
initial begin
 repeat(3) @(posedge c);
 r<=0;
 t_sys; t_vec; t_gate; t_addr; t_bak;
 stop_test;
end
initial begin
 repeat(500) @(posedge c);
 n_mismatch++;
 stop_test;
end
endmodule
